// *** hdl/pfc_controller.sv ***
`timescale 1ns/1ps
`include "pfc_params.svh"
module pfc_controller #(
    parameter int TICK_CYCLES = `PFC_TICK_CYCLES // Control tick period
) (
    input wire logic clk, // 40 MHz clock
    input wire logic reset, // Async, active high
    input wire logic hsel, // AHB select
    input wire logic [7:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic [31:0] hrdata, // AHB read data
    output logic hreadyout, // AHB slave ready
    output logic hresp, // AHB response, always OKAY
    input wire logic [13:0] voltageFeedbackInput, // Voltage feedback, 0.01 %
    input wire logic [13:0] currentFeedbackInput, // Current feedback, 0.01 %
    input wire logic [13:0] analogSetpoint, // Analog or step target, 0.01 %
    output logic [15:0] outFreq, // Regulated frequency, 0.01 Hz
    output logic pidActive, // Regulation running
    output logic feedbackWarning, // Feedback fault warning
    output logic rampStop, // Request ramp to stop
    output logic coastStop, // Request coast to stop
    output logic irq // Level interrupt
);
    pfc_pkg::pfc_cfg_t cfg_ff; // Software settings
    pfc_pkg::pfc_sup_t sup_ff; // Supervisor state
    logic [1:0] stat_ff; // Sticky events
    logic [1:0] mask_ff; // Interrupt mask
    logic [13:0] vSync1_ff, vSync2_ff; // Voltage synchroniser
    logic [13:0] cSync1_ff, cSync2_ff; // Current synchroniser
    logic [13:0] sSync1_ff, sSync2_ff; // Setpoint synchroniser
    logic [31:0] tickCnt_ff; // Tick divider
    logic tick; // One-cycle tick
    logic signed [31:0] integ_ff, prevDev_ff, filt_ff, dev_ff; // Loop state
    logic [31:0] abnCnt_ff; // Abnormal tick count
    logic [7:0] addr_ff; // Latched address
    logic wrPend_ff; // Write data phase pending
    logic signed [31:0] fb, target, dev, pTerm, nxt_integ, dRaw, nxt_filt, sum, iBound, oLim, absDev;
    logic saturated; // Output hit its limit
    logic abnormal; // Feedback out of range
    logic [31:0] faultTicks; // Detection time in ticks
    logic rdStat; // Status read this cycle

    // Two flops before any logic looks at the analog pins
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            vSync1_ff <= 14'h0000;
            vSync2_ff <= 14'h0000;
            cSync1_ff <= 14'h0000;
            cSync2_ff <= 14'h0000;
            sSync1_ff <= 14'h0000;
            sSync2_ff <= 14'h0000;
        end else begin
            vSync1_ff <= voltageFeedbackInput;
            vSync2_ff <= vSync1_ff;
            cSync1_ff <= currentFeedbackInput;
            cSync2_ff <= cSync1_ff;
            sSync1_ff <= analogSetpoint;
            sSync2_ff <= sSync1_ff;
        end
    end

    // Control tick divider
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tickCnt_ff <= 32'h0000_0000;
        end else if (tickCnt_ff == 32'(TICK_CYCLES - 1)) begin
            tickCnt_ff <= 32'h0000_0000;
        end else begin
            tickCnt_ff <= tickCnt_ff + 32'h0000_0001;
        end
    end
    assign tick = (tickCnt_ff == 32'(TICK_CYCLES - 1));

    // Loop arithmetic in 0.01 % of maximum frequency
    always_comb begin
        // Feedback channel pick, scaled by gain
        fb = (cfg_ff.fbSel == 3'h2 || cfg_ff.fbSel == 3'h4) ? 32'(cSync2_ff) : 32'(vSync2_ff);
        fb = (fb * 32'(cfg_ff.fbGain)) / `PFC_GAIN_DIV;
        target = (cfg_ff.spSel == 2'h0) ? 32'(cfg_ff.keypad) : 32'(sSync2_ff);
        dev = (cfg_ff.fbSel >= 3'h3) ? fb - target : target - fb;
        pTerm = (signed'(32'(cfg_ff.pGain)) * dev) / signed'(`PFC_PGAIN_DIV);
        iBound = 32'(cfg_ff.iBoundPct) * `PFC_PCT_SCALE;
        // One tick equals one unit of integral time
        if (cfg_ff.iTime == 14'h0000) begin
            nxt_integ = 32'sh0000_0000;
        end else begin
            nxt_integ = integ_ff + dev / signed'(32'(cfg_ff.iTime));
        end
        // Symmetric clamp keeps windup bounded both ways
        if (nxt_integ > iBound) begin
            nxt_integ = iBound;
        end else if (nxt_integ < -iBound) begin
            nxt_integ = -iBound;
        end
        dRaw = signed'(32'(cfg_ff.dTime)) * (dev - prevDev_ff);
        // Filter divisor grows with time constant; zero passes straight
        nxt_filt = filt_ff + (dRaw - filt_ff) / signed'(32'(cfg_ff.filtTime) * `PFC_TICKS_PER_DS + 32'h1);
        oLim = 32'(cfg_ff.outLimitPct) * `PFC_PCT_SCALE;
        sum = pTerm + nxt_integ + nxt_filt;
        saturated = (sum > oLim);
        if (sum > oLim) begin
            sum = oLim;
        end
        if (sum < 32'sh0000_0000) begin
            sum = 32'sh0000_0000;
        end
        absDev = (target > fb) ? target - fb : fb - target;
        abnormal = (absDev > 32'(cfg_ff.devRange));
        faultTicks = 32'(cfg_ff.faultTime) * `PFC_TICKS_PER_DS;
    end

    // Loop state and output, one update per tick
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            integ_ff <= 32'sh0000_0000;
            prevDev_ff <= 32'sh0000_0000;
            filt_ff <= 32'sh0000_0000;
            dev_ff <= 32'sh0000_0000;
            outFreq <= 16'h0000;
            pidActive <= 1'b0;
        end else if (tick) begin
            if (cfg_ff.fbSel == 3'h0 || cfg_ff.fbSel > 3'h4) begin
                // Regulation off: analog inputs free for other use
                integ_ff <= 32'sh0000_0000;
                prevDev_ff <= 32'sh0000_0000;
                filt_ff <= 32'sh0000_0000;
                dev_ff <= 32'sh0000_0000;
                outFreq <= 16'h0000;
                pidActive <= 1'b0;
            end else begin
                // Settings are read live every tick
                integ_ff <= nxt_integ;
                prevDev_ff <= dev;
                filt_ff <= nxt_filt;
                dev_ff <= dev;
                outFreq <= 16'((sum * 32'(cfg_ff.maxFreq)) / `PFC_FULL_SCALE);
                pidActive <= 1'b1;
            end
        end
    end

    // Feedback abnormality supervisor
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sup_ff <= pfc_pkg::PFC_IDLE;
            abnCnt_ff <= 32'h0000_0000;
        end else if (tick) begin
            case (sup_ff)
                pfc_pkg::PFC_IDLE: begin
                    abnCnt_ff <= 32'h0000_0001;
                    if (pidActive && abnormal && cfg_ff.faultTime != 16'h0000) begin
                        sup_ff <= pfc_pkg::PFC_TIMING;
                    end
                end
                pfc_pkg::PFC_TIMING: begin
                    // Any normal sample restarts the wait
                    if (!abnormal || !pidActive || cfg_ff.faultTime == 16'h0000) begin
                        sup_ff <= pfc_pkg::PFC_IDLE;
                    end else if (abnCnt_ff >= faultTicks) begin
                        sup_ff <= pfc_pkg::PFC_FAULTED;
                    end else begin
                        abnCnt_ff <= abnCnt_ff + 32'h0000_0001;
                    end
                end
                pfc_pkg::PFC_FAULTED: begin
                    // Warning clears when feedback recovers
                    if (!abnormal || !pidActive || cfg_ff.faultTime == 16'h0000) begin
                        sup_ff <= pfc_pkg::PFC_IDLE;
                    end
                end
                default: begin
                    sup_ff <= pfc_pkg::PFC_IDLE;
                end
            endcase
        end
    end

    // Warning and stop requests per treatment setting
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            feedbackWarning <= 1'b0;
            rampStop <= 1'b0;
            coastStop <= 1'b0;
        end else begin
            feedbackWarning <= (sup_ff == pfc_pkg::PFC_FAULTED);
            rampStop <= (sup_ff == pfc_pkg::PFC_FAULTED) && (cfg_ff.faultAction == 2'h1);
            coastStop <= (sup_ff == pfc_pkg::PFC_FAULTED) && (cfg_ff.faultAction == 2'h2);
        end
    end

    // AHB-Lite slave, zero wait states
    assign rdStat = hsel && hready && htrans[1] && !hwrite && (haddr == `PFC_ADDR_STATUS);
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            addr_ff <= 8'h00;
            wrPend_ff <= 1'b0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hready) begin
                addr_ff <= haddr;
                wrPend_ff <= hsel && htrans[1] && hwrite;
            end
        end
    end

    // Read data captured in the address phase
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hrdata <= 32'h0000_0000;
        end else if (hsel && hready && htrans[1] && !hwrite) begin
            case (haddr)
                `PFC_ADDR_CTRL: hrdata <= {22'h0, cfg_ff.faultAction, 2'h0, cfg_ff.spSel, 1'b0, cfg_ff.fbSel};
                `PFC_ADDR_FBGAIN: hrdata <= {22'h0, cfg_ff.fbGain};
                `PFC_ADDR_PGAIN: hrdata <= {25'h0, cfg_ff.pGain};
                `PFC_ADDR_ITIME: hrdata <= {18'h0, cfg_ff.iTime};
                `PFC_ADDR_DTIME: hrdata <= {25'h0, cfg_ff.dTime};
                `PFC_ADDR_IBOUND: hrdata <= {25'h0, cfg_ff.iBoundPct};
                `PFC_ADDR_FILT: hrdata <= {27'h0, cfg_ff.filtTime};
                `PFC_ADDR_OLIM: hrdata <= {25'h0, cfg_ff.outLimitPct};
                `PFC_ADDR_FTIME: hrdata <= {16'h0, cfg_ff.faultTime};
                `PFC_ADDR_DEVRNG: hrdata <= {18'h0, cfg_ff.devRange};
                `PFC_ADDR_MAXFRQ: hrdata <= {16'h0, cfg_ff.maxFreq};
                `PFC_ADDR_KEYPAD: hrdata <= {18'h0, cfg_ff.keypad};
                `PFC_ADDR_STATUS: hrdata <= {30'h0, stat_ff};
                `PFC_ADDR_MASK: hrdata <= {30'h0, mask_ff};
                `PFC_ADDR_OUTFRQ: hrdata <= {16'h0, outFreq};
                `PFC_ADDR_DEV: hrdata <= dev_ff;
                default: hrdata <= 32'h0000_0000; // Unmapped reads zero
            endcase
        end
    end

    // Register writes in the data phase
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_ff <= '{3'h0, 2'h0, 2'h0, `PFC_RST_FBGAIN, `PFC_RST_PGAIN, `PFC_RST_ITIME, `PFC_RST_DTIME,
                `PFC_RST_IBOUND, `PFC_RST_FILT, `PFC_RST_OLIM, `PFC_RST_FTIME, `PFC_RST_DEVRNG,
                `PFC_RST_MAXFRQ, 14'h0000};
            mask_ff <= 2'h0;
        end else if (wrPend_ff) begin
            case (addr_ff)
                `PFC_ADDR_CTRL: begin
                    cfg_ff.fbSel <= hwdata[2:0];
                    cfg_ff.spSel <= hwdata[5:4];
                    cfg_ff.faultAction <= hwdata[9:8];
                end
                `PFC_ADDR_FBGAIN: cfg_ff.fbGain <= hwdata[9:0];
                `PFC_ADDR_PGAIN: cfg_ff.pGain <= hwdata[6:0];
                `PFC_ADDR_ITIME: cfg_ff.iTime <= hwdata[13:0];
                `PFC_ADDR_DTIME: cfg_ff.dTime <= hwdata[6:0];
                `PFC_ADDR_IBOUND: cfg_ff.iBoundPct <= hwdata[6:0];
                `PFC_ADDR_FILT: cfg_ff.filtTime <= hwdata[4:0];
                `PFC_ADDR_OLIM: cfg_ff.outLimitPct <= hwdata[6:0];
                `PFC_ADDR_FTIME: cfg_ff.faultTime <= hwdata[15:0];
                `PFC_ADDR_DEVRNG: cfg_ff.devRange <= hwdata[13:0];
                `PFC_ADDR_MAXFRQ: cfg_ff.maxFreq <= hwdata[15:0];
                `PFC_ADDR_KEYPAD: cfg_ff.keypad <= hwdata[13:0];
                `PFC_ADDR_MASK: mask_ff <= hwdata[1:0];
                default: ; // Read-only and unmapped ignore writes
            endcase
        end
    end

    // Sticky events; a new event beats the read clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stat_ff <= 2'h0;
            irq <= 1'b0;
        end else begin
            stat_ff[`PFC_ST_FAULT] <= (stat_ff[`PFC_ST_FAULT] && !rdStat)
                || (sup_ff == pfc_pkg::PFC_FAULTED && !feedbackWarning);
            stat_ff[`PFC_ST_SAT] <= (stat_ff[`PFC_ST_SAT] && !rdStat) || (tick && pidActive && saturated);
            irq <= |(stat_ff & mask_ff);
        end
    end

    sequence sqEnterFault;
        (sup_ff != pfc_pkg::PFC_FAULTED) ##1 (sup_ff == pfc_pkg::PFC_FAULTED);
    endsequence
    AST_OFF_ZERO: assert property (@(posedge clk) disable iff (reset)
        (tick && cfg_ff.fbSel == 3'h0) |=> (outFreq == 16'h0000 && !pidActive))
        else $error("Output not zero while regulation off");
    AST_NEG_SENSE: assert property (@(posedge clk) disable iff (reset)
        (cfg_ff.fbSel == 3'h1 && cfg_ff.spSel == 2'h0)
            |-> (dev == 32'(cfg_ff.keypad) - 32'(vSync2_ff) * 32'(cfg_ff.fbGain) / `PFC_GAIN_DIV))
        else $error("Negative sense deviation wrong");
    AST_POS_SENSE: assert property (@(posedge clk) disable iff (reset)
        (cfg_ff.fbSel == 3'h3 && cfg_ff.spSel == 2'h0)
            |-> (dev == 32'(vSync2_ff) * 32'(cfg_ff.fbGain) / `PFC_GAIN_DIV - 32'(cfg_ff.keypad)))
        else $error("Positive sense deviation wrong");
    AST_ITIME_OFF: assert property (@(posedge clk) disable iff (reset)
        (tick && pidActive && cfg_ff.iTime == 14'h0000 && cfg_ff.fbSel != 3'h0) |=> (integ_ff == 0))
        else $error("Integral active with zero time");
    AST_IBOUND: assert property (@(posedge clk) disable iff (reset)
        $changed(integ_ff) |-> (integ_ff <= $past(iBound)))
        else $error("Integral above bound");
    AST_OUT_LIMIT: assert property (@(posedge clk) disable iff (reset)
        $changed(outFreq) |-> (32'(outFreq) <= $past(oLim) * 32'($past(cfg_ff.maxFreq)) / `PFC_FULL_SCALE))
        else $error("Output above limit");
    AST_NO_DETECT: assert property (@(posedge clk) disable iff (reset)
        (cfg_ff.faultTime == 16'h0000 && sup_ff != pfc_pkg::PFC_FAULTED) |=> (sup_ff != pfc_pkg::PFC_FAULTED))
        else $error("Fault with detection off");
    AST_WAIT_FIRST: assert property (@(posedge clk) disable iff (reset)
        sqEnterFault |-> ($past(sup_ff) == pfc_pkg::PFC_TIMING && $past(abnCnt_ff) >= $past(faultTicks)))
        else $error("Fault without abnormal wait");
    AST_COAST: assert property (@(posedge clk) disable iff (reset)
        (sup_ff == pfc_pkg::PFC_FAULTED && cfg_ff.faultAction == 2'h2) |=> coastStop || $changed(cfg_ff))
        else $error("Coast stop not requested");
    AST_STAT_SET: assert property (@(posedge clk) disable iff (reset)
        (sup_ff == pfc_pkg::PFC_FAULTED && !feedbackWarning) |=> stat_ff[`PFC_ST_FAULT])
        else $error("Fault event lost");
endmodule // pfc_controller

// *** hdl/pfc_params.svh ***
`ifndef PFC_PARAMS_SVH
`define PFC_PARAMS_SVH
// Register byte offsets
`define PFC_ADDR_CTRL 8'h00
`define PFC_ADDR_FBGAIN 8'h04
`define PFC_ADDR_PGAIN 8'h08
`define PFC_ADDR_ITIME 8'h0C
`define PFC_ADDR_DTIME 8'h10
`define PFC_ADDR_IBOUND 8'h14
`define PFC_ADDR_FILT 8'h18
`define PFC_ADDR_OLIM 8'h1C
`define PFC_ADDR_FTIME 8'h20
`define PFC_ADDR_DEVRNG 8'h24
`define PFC_ADDR_MAXFRQ 8'h28
`define PFC_ADDR_KEYPAD 8'h2C
`define PFC_ADDR_STATUS 8'h30
`define PFC_ADDR_MASK 8'h34
`define PFC_ADDR_OUTFRQ 8'h38
`define PFC_ADDR_DEV 8'h3C
// Reset values, in setting units
`define PFC_RST_FBGAIN 10'h064
`define PFC_RST_PGAIN 7'h0A
`define PFC_RST_ITIME 14'h0064
`define PFC_RST_DTIME 7'h00
`define PFC_RST_IBOUND 7'h64
`define PFC_RST_FILT 5'h00
`define PFC_RST_OLIM 7'h64
`define PFC_RST_FTIME 16'h0258
`define PFC_RST_DEVRNG 14'h2710
`define PFC_RST_MAXFRQ 16'h1770
// Scale factors
`define PFC_GAIN_DIV 32'h0000_0064
`define PFC_PGAIN_DIV 32'h0000_000A
`define PFC_PCT_SCALE 32'h0000_0064
`define PFC_FULL_SCALE 32'h0000_2710
`define PFC_TICKS_PER_DS 32'h0000_000A
// Control tick: 10 ms at 40 MHz
`define PFC_TICK_US 10000
`define PFC_CLK_MHZ 40
`define PFC_TICK_CYCLES (`PFC_TICK_US * `PFC_CLK_MHZ)
// Status bit positions
`define PFC_ST_FAULT 0
`define PFC_ST_SAT 1
`endif

// *** hdl/pfc_pkg.sv ***
package pfc_pkg;
    // Settings that steer the loop
    typedef struct packed {
        logic [2:0] fbSel;
        logic [1:0] spSel;
        logic [1:0] faultAction;
        logic [9:0] fbGain;
        logic [6:0] pGain;
        logic [13:0] iTime;
        logic [6:0] dTime;
        logic [6:0] iBoundPct;
        logic [4:0] filtTime;
        logic [6:0] outLimitPct;
        logic [15:0] faultTime;
        logic [13:0] devRange;
        logic [15:0] maxFreq;
        logic [13:0] keypad;
    } pfc_cfg_t;
    // Feedback abnormality supervisor
    typedef enum logic [1:0] {
        PFC_IDLE = 2'b00,
        PFC_TIMING = 2'b01,
        PFC_FAULTED = 2'b10
    } pfc_sup_t;
endpackage

// *** bench/pfc_fb_source.sv ***
`timescale 1ns/1ps
// Far side of the loop: the digitised transducer and target levels.
// The converter is ideal: no noise and no conversion delay.
// The synchronising flops inside the regulator supply all the latency.
module pfc_fb_source (
    input wire logic [13:0] voltLvl, // Wanted voltage level
    input wire logic [13:0] currLvl, // Wanted current level
    input wire logic [13:0] spLvl, // Wanted analog target
    output logic [13:0] voltageFeedbackInput, // Voltage sample, 0.01 %
    output logic [13:0] currentFeedbackInput, // Current sample, 0.01 %
    output logic [13:0] analogSetpoint // Target sample, 0.01 %
);
    // Levels pass straight through
    assign voltageFeedbackInput = voltLvl;
    assign currentFeedbackInput = currLvl;
    assign analogSetpoint = spLvl;
endmodule // pfc_fb_source

// *** bench/tb_pid_feedback_controller.sv ***
`timescale 1ns/1ps
// Self-checking bench for the PID regulator
module tb_pid_feedback_controller;
    localparam int TICK = 20; // Short tick keeps the run brief
    localparam logic [31:0] RST_TAB [14] = '{32'h0, 32'h64, 32'hA, 32'h64, 32'h0, 32'h64, 32'h0,
        32'h64, 32'h258, 32'h2710, 32'h1770, 32'h0, 32'h0, 32'h0}; // Reset value per word
    logic clk; // Loop and bus clock
    logic reset; // Async reset
    logic hsel; // Select
    logic [7:0] haddr; // Byte address
    logic [1:0] htrans; // Transfer type
    logic hwrite; // Write flag
    logic [2:0] hsize; // Always a word
    logic [31:0] hwdata; // Write data
    logic [31:0] hrdata; // Read data
    logic hreadyout; // Slave ready, also the bus ready
    logic hresp; // Response
    logic [13:0] voltLvl; // Wanted voltage
    logic [13:0] currLvl; // Wanted current
    logic [13:0] spLvl; // Wanted analog target
    logic [13:0] vFb; // Converted voltage
    logic [13:0] cFb; // Converted current
    logic [13:0] aSp; // Converted target
    logic [15:0] outFreq; // Regulated frequency
    logic pidActive; // Loop running
    logic feedbackWarning; // Fault warning
    logic rampStop; // Ramp request
    logic coastStop; // Coast request
    logic irq; // Interrupt
    int n_fail = 0; // Mismatches
    int n_tests = 0; // Compares

    pfc_fb_source src (.voltLvl(voltLvl), .currLvl(currLvl), .spLvl(spLvl),
        .voltageFeedbackInput(vFb), .currentFeedbackInput(cFb), .analogSetpoint(aSp));
    pfc_controller #(.TICK_CYCLES(TICK)) dut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .voltageFeedbackInput(vFb),
        .currentFeedbackInput(cFb), .analogSetpoint(aSp), .outFreq(outFreq), .pidActive(pidActive),
        .feedbackWarning(feedbackWarning), .rampStop(rampStop), .coastStop(coastStop), .irq(irq));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Hang guard
    initial begin
        #2500000;
        n_fail++;
        give_verdict();
    end
    // Counts, verdict, end of run
    task automatic give_verdict();
        $display("Compares %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Four-state compare
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bounded wait for ready at a rising edge
    task automatic wait_rdy();
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 64);
        if (hreadyout !== 1'b1) begin
            n_fail++;
            give_verdict();
        end
    endtask
    // One word: address phase, then data phase
    task automatic xfer(input logic isWr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= isWr;
        htrans <= 2'h2;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        chk(32'(hresp), 32'h0); // Response always OKAY
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] junk;
        xfer(1'b1, a, d, junk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] got;
        xfer(1'b0, a, 32'h0, got);
        chk(got, e);
    endtask
    // Watched output by index
    function automatic logic [31:0] obs(input int s);
        case (s)
            0: return 32'(outFreq);
            1: return 32'(feedbackWarning);
            default: return 32'(irq);
        endcase
    endfunction
    // Bounded wait for a value; sampled at falling edges, away from updates
    task automatic poll(input int s, input logic [31:0] exp, input int nTick);
        int k;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (obs(s) !== exp && k < nTick * TICK);
        chk(obs(s), exp);
        if (obs(s) !== exp) begin
            give_verdict();
        end
        @(posedge clk);
    endtask
    // Fixed number of ticks, then judge
    task automatic snap(input int s, input logic [31:0] exp, input int nTick);
        repeat (nTick * TICK) @(negedge clk);
        chk(obs(s), exp);
        @(posedge clk);
    endtask

    task automatic t_reset();
        for (int i = 0; i < 14; i++) begin
            rchk(8'(i * 4), RST_TAB[i]);
        end
        wr(8'h40, 32'hFFFF_FFFF);
        rchk(8'h40, 32'h0); // Unmapped reads zero
        voltLvl <= 14'h0BB8;
        snap(0, 32'h0, 3);
        chk(32'(pidActive), 32'h0);
        $display("Reset test done");
    endtask
    task automatic t_sense();
        logic [31:0] expF [4] = '{32'h4B0, 32'h258, 32'h0, 32'h0};
        logic [31:0] expD [4] = '{32'h7D0, 32'h3E8, 32'hFFFF_F830, 32'hFFFF_FC18};
        wr(8'h0C, 32'h0);
        wr(8'h2C, 32'h1388);
        currLvl <= 14'h0FA0;
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, 32'(i + 1));
            snap(0, expF[i], 3);
            rchk(8'h3C, expD[i]);
            chk(32'(pidActive), 32'h1);
        end
        spLvl <= 14'h1770;
        for (int s = 1; s < 3; s++) begin
            wr(8'h00, 32'(s * 16 + 1));
            snap(0, 32'h708, 3);
        end
        $display("Sense test done");
    endtask
    // Gains and limits changed while running
    task automatic t_gain();
        wr(8'h00, 32'h1);
        wr(8'h04, 32'h32);
        wr(8'h08, 32'h14);
        snap(0, 32'h1068, 3);
        wr(8'h1C, 32'h32);
        snap(0, 32'hBB8, 3);
        wr(8'h28, 32'h1388);
        snap(0, 32'h9C4, 3);
        rchk(8'h30, 32'h2); // Saturation flag
        wr(8'h1C, 32'h64);
        wr(8'h28, 32'h1770);
        wr(8'h04, 32'h64);
        wr(8'h08, 32'h0);
        $display("Gain test done");
    endtask
    task automatic t_integral();
        snap(0, 32'h0, 3);
        wr(8'h0C, 32'hA);
        poll(0, 32'h78, 4);
        snap(0, 32'h4B0, 9);
        wr(8'h14, 32'hA);
        poll(0, 32'h258, 4);
        wr(8'h0C, 32'h0);
        poll(0, 32'h0, 4);
        wr(8'h14, 32'h64);
        $display("Integral test done");
    endtask
    task automatic t_deriv();
        voltLvl <= 14'h1388;
        wr(8'h10, 32'h32);
        snap(0, 32'h0, 3);
        voltLvl <= 14'h0BB8;
        poll(0, 32'h1770, 4);
        snap(0, 32'h0, 1);
        wr(8'h18, 32'h1);
        wr(8'h2C, 32'h1B58);
        poll(0, 32'h154E, 4);
        snap(0, 32'h135E, 1);
        $display("Derivative test done");
    endtask
    // Supervisor: delay, actions, interrupt, range edge, disable
    task automatic t_fault();
        logic [31:0] junk;
        wr(8'h10, 32'h0);
        wr(8'h18, 32'h0);
        wr(8'h08, 32'hA);
        wr(8'h2C, 32'h1388);
        voltLvl <= 14'h1388;
        wr(8'h24, 32'h3E8);
        wr(8'h20, 32'h1);
        snap(1, 32'h0, 3);
        xfer(1'b0, 8'h30, 32'h0, junk);
        for (int a = 0; a < 3; a++) begin
            wr(8'h34, 32'(a != 2));
            wr(8'h00, 32'(a * 256 + 1));
            voltLvl <= 14'h0BB8;
            snap(1, 32'h0, 8);
            poll(1, 32'h1, 6);
            chk(32'(rampStop), 32'(a == 1));
            chk(32'(coastStop), 32'(a == 2));
            poll(2, 32'(a != 2), 1); // Masked fault keeps line low
            rchk(8'h30, 32'h1); // Fault status
            poll(2, 32'h0, 1); // Read clears
            voltLvl <= 14'h1388;
            poll(1, 32'h0, 4); // Recovery
        end
        voltLvl <= 14'h0FA0;
        snap(1, 32'h0, 15);
        wr(8'h20, 32'h0);
        voltLvl <= 14'h0BB8;
        snap(1, 32'h0, 15);
        $display("Fault test done");
    endtask

    initial begin
        reset = 1'b1;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        voltLvl = 14'h0000;
        currLvl = 14'h0000;
        spLvl = 14'h0000;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_reset();
        t_sense();
        t_gain();
        t_integral();
        t_deriv();
        t_fault();
        give_verdict();
    end
endmodule // tb_pid_feedback_controller
